// file: verilog/cof_top.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cof_top
  import cof_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic             mclk,
  input  wire logic             arst_n,
  input  wire logic [AW-1:0]    reg_addr,
  input  wire logic [DW-1:0]    reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [DW-1:0]         reg_rdata,
  input  wire logic             arm_trigger_in,
  input  wire logic             inhibit_in,
  input  wire logic             protection_start_in,
  input  wire logic [GRP_W-1:0] setting_group_choice,
  output logic                  window_active_out,
  output logic                  fast_trip_out,
  output cof_evt_s              evt_out,
  output logic                  irq
);
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("cof_top: TICK_CYCLES must be at least 2");
  end
  if (NGRP != (1 << GRP_W)) begin : g_bad_grp
    $error("cof_top: NGRP must match GRP_W");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [GRP_W-1:0] grp_s;
  logic             arm_s;
  logic             blk_s;
  logic             fcn_s;
  logic             arm_d_r;
  logic             arm_rise;

  // outside signals land two flops late; the trip path is counted from here
  cof_sync #(
    .W (GRP_W + 3)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      ({setting_group_choice, protection_start_in, inhibit_in, arm_trigger_in}),
    .q      ({grp_s, fcn_s, blk_s, arm_s})
  );

  // any binary source works: its edge opens the window, its level raises the init flag
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      arm_d_r <= 1'b0;
    end else begin
      arm_d_r <= arm_s;
    end
  end
  assign arm_rise = arm_s & ~arm_d_r;

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  logic [9:0]       ctrl_r;
  logic [LEN_W-1:0] len_r [NGRP];
  logic [7:0]       irq_stat_r;
  logic [7:0]       irq_mask_r;
  logic [3:0]       lsel_r;
  logic             wr_ctrl;
  logic             wr_irq;
  logic             wr_mask;
  logic             wr_lsel;
  logic [NEV-1:0]   wr_cnt;
  logic [NGRP-1:0]  wr_len;
  cof_mode_e        mode;
  cof_force_e       force_sel;
  logic             ev_on_sel;
  logic             ev_off_sel;

  assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
  assign wr_irq  = reg_wr && reg_addr == OFS_IRQ;
  assign wr_mask = reg_wr && reg_addr == OFS_MASK;
  assign wr_lsel = reg_wr && reg_addr == OFS_LSEL;

  // per-counter clear strobes and per-group length strobes
  for (genvar k = 0; k < NEV; k++) begin : g_cnt_dec
    assign wr_cnt[k] = reg_wr && reg_addr == OFS_CNT + AW'(4 * k);
  end
  for (genvar g = 0; g < NGRP; g++) begin : g_len_dec
    assign wr_len[g] = reg_wr && reg_addr == OFS_LEN + AW'(4 * g);
  end

  // an undefined mode code falls back to off, the safe side
  always_comb begin
    case (ctrl_r[CTRL_MODE_LSB +: 3])
      3'b000:  mode = COF_MODE_ON;
      3'b001:  mode = COF_MODE_BLOCKED;
      3'b010:  mode = COF_MODE_TEST;
      3'b011:  mode = COF_MODE_TESTBLK;
      default: mode = COF_MODE_OFF;
    endcase
  end
  assign force_sel  = cof_force_e'(ctrl_r[CTRL_FORCE_LSB +: 2]);
  assign ev_on_sel  = ctrl_r[CTRL_EVON_BIT];
  assign ev_off_sel = ctrl_r[CTRL_EVOFF_BIT];

  // control word: mode, force and event selection
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
      lsel_r <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[9:0];
      end
      if (wr_lsel) begin
        lsel_r <= reg_wdata[3:0];
      end
    end
  end

  // lengths in ms, clamped to the longest legal window
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int g = 0; g < NGRP; g++) begin
        len_r[g] <= LEN_RST_MS;
      end
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        if (wr_len[g]) begin
          len_r[g] <= (reg_wdata > DW'(LEN_MAX_MS)) ? LEN_MAX_MS : reg_wdata[LEN_W-1:0];
        end
      end
    end
  end

  // ----------------------------------------
  // timebase and window timer
  // ----------------------------------------
  logic [31:0]      pre_r;
  logic             tick;
  logic [31:0]      stamp_r;
  logic             mode_run;
  logic             mode_blk;
  logic             start;
  logic             run_r;
  logic [LEN_W-1:0] elapsed_r;
  logic [LEN_W-1:0] len_cur;
  logic [LEN_W-1:0] left;

  assign tick     = pre_r == 32'(TICK_CYCLES - 1);
  assign mode_run = mode == COF_MODE_ON || mode == COF_MODE_TEST;
  assign mode_blk = mode == COF_MODE_BLOCKED || mode == COF_MODE_TESTBLK;
  assign start    = arm_rise && mode_run && !blk_s;
  assign len_cur  = len_r[grp_s];
  assign left     = run_r ? len_cur - elapsed_r : '0;

  // millisecond prescaler and free running stamp
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r   <= '0;
      stamp_r <= '0;
    end else begin
      pre_r <= tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
      if (tick) begin
        stamp_r <= stamp_r + 32'h0000_0001;
      end
    end
  end

  // an edge during the window restarts it from zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run_r     <= 1'b0;
      elapsed_r <= '0;
    end else if (!mode_run) begin
      run_r     <= 1'b0;
      elapsed_r <= '0;
    end else if (start) begin
      run_r     <= len_cur != '0;
      elapsed_r <= '0;
    end else if (run_r && elapsed_r >= len_cur) begin
      run_r     <= 1'b0;
    end else if (run_r && tick) begin
      elapsed_r <= elapsed_r + LEN_W'(1);
      run_r     <= elapsed_r + LEN_W'(1) < len_cur;
    end
  end

  // ----------------------------------------
  // condition, force and outputs
  // ----------------------------------------
  logic [NEV-1:0] fl;
  logic [NEV-1:0] fl_r;
  logic [NEV-1:0] ev_on;
  logic [NEV-1:0] ev_off;
  cof_cond_e      cond;

  // forcing overrides the computed flags, and thus outputs and events
  always_comb begin
    fl = '0;
    case (force_sel)
      COF_FRC_BLOCKED: fl[COF_EV_BLOCK] = 1'b1;
      COF_FRC_ACTIVE:  fl[COF_EV_ACTIVE] = 1'b1;
      COF_FRC_TRIP: begin
        fl[COF_EV_ACTIVE] = 1'b1;
        fl[COF_EV_TRIP]   = 1'b1;
      end
      default: begin
        fl[COF_EV_INIT]   = mode_run && arm_s && !blk_s;
        fl[COF_EV_BLOCK]  = mode_blk || (mode_run && blk_s);
        fl[COF_EV_ACTIVE] = run_r;
        fl[COF_EV_TRIP]   = run_r && fcn_s;
      end
    endcase
  end

  // highest condition wins when several flags stand
  always_comb begin
    if (fl[COF_EV_TRIP]) begin
      cond = COF_COND_TRIP;
    end else if (fl[COF_EV_ACTIVE]) begin
      cond = COF_COND_ACTIVE;
    end else if (fl[COF_EV_BLOCK]) begin
      cond = COF_COND_BLOCKED;
    end else if (fl[COF_EV_INIT]) begin
      cond = COF_COND_INIT;
    end else begin
      cond = COF_COND_NORMAL;
    end
  end

  // COF_MODE_TEST runs the logic but keeps the trip off the output; COF_MODE_TESTBLK does not gate it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      window_active_out <= 1'b0;
      fast_trip_out     <= 1'b0;
      fl_r              <= '0;
    end else begin
      window_active_out <= fl[COF_EV_ACTIVE];
      fast_trip_out     <= fl[COF_EV_TRIP] && mode != COF_MODE_TEST;
      fl_r              <= fl;
    end
  end
  assign ev_on  = fl & ~fl_r;
  assign ev_off = ~fl & fl_r;

  // ----------------------------------------
  // events, counters, interrupts
  // ----------------------------------------
  logic [CNT_W-1:0] cnt_r [NEV];

  // stamped, filtered event pulses toward the main buffer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_out <= '0;
    end else begin
      evt_out.on    <= ev_on_sel ? ev_on : '0;
      evt_out.off   <= ev_off_sel ? ev_off : '0;
      evt_out.stamp <= stamp_r;
    end
  end

  // an event in the clear cycle counts as one, not zero
  for (genvar k = 0; k < NEV; k++) begin : g_cnt
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_r[k] <= '0;
      end else if (wr_cnt[k]) begin
        cnt_r[k] <= CNT_W'(ev_on[k]);
      end else if (ev_on[k]) begin
        cnt_r[k] <= cnt_r[k] + CNT_W'(1);
      end
    end
  end

  // sticky status, write one to clear, new event wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wr_irq ? reg_wdata[7:0] : 8'h00)) | {ev_off, ev_on};
      if (wr_mask) begin
        irq_mask_r <= reg_wdata[7:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------
  // activation log
  // ----------------------------------------
  cof_log_s log_wr;
  cof_log_s log_rd;
  logic [7:0] log_cnt;

  assign log_wr = '{stamp: stamp_r, kind: COF_EV_ACTIVE, grp: grp_s,
                    left: left, elapsed: elapsed_r};

  cof_log #(
    .DEPTH (LOG_DEPTH)
  ) u_log (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .wr_en   (ev_on[COF_EV_ACTIVE]),
    .wr_data (log_wr),
    .rd_idx  (lsel_r),
    .rd_data (log_rd),
    .count   (log_cnt)
  );

  // ----------------------------------------
  // read path, data one cycle after the strobe
  // ----------------------------------------
  logic [DW-1:0] rd_nxt;

  always_comb begin
    rd_nxt = '0;
    case (reg_addr)
      OFS_CTRL: rd_nxt = DW'(ctrl_r);
      OFS_STAT: rd_nxt = DW'({mode, 1'b0, cond});
      OFS_IRQ:  rd_nxt = DW'(irq_stat_r);
      OFS_MASK: rd_nxt = DW'(irq_mask_r);
      OFS_LEFT: rd_nxt = DW'(left);
      OFS_TIME: rd_nxt = stamp_r;
      OFS_LSEL: rd_nxt = DW'({log_cnt, 4'h0, lsel_r});
      OFS_LTS:  rd_nxt = log_rd.stamp;
      OFS_LINF: rd_nxt = DW'({log_rd.kind, 1'b0, log_rd.grp, 3'b000, log_rd.left});
      OFS_LELP: rd_nxt = DW'(log_rd.elapsed);
      default: begin
        for (int k = 0; k < NEV; k++) begin
          if (reg_addr == OFS_CNT + AW'(4 * k)) begin
            rd_nxt = DW'(cnt_r[k]);
          end
        end
        for (int g = 0; g < NGRP; g++) begin
          if (reg_addr == OFS_LEN + AW'(4 * g)) begin
            rd_nxt = DW'(len_r[g]);
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_nxt : '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence seq_clean_arm;
    arm_rise && !blk_s && mode == COF_MODE_ON && len_cur != '0
    && force_sel == COF_FRC_NORMAL;
  endsequence
  sequence seq_window_up;
    run_r ##1 window_active_out;
  endsequence

  chk_arm_opens: assert property (
    seq_clean_arm |=> seq_window_up)
    else $error("clean arm edge did not open the window");
  chk_arm_edge_only: assert property (
    $rose(run_r) |-> $past(arm_rise))
    else $error("window opened without an arm edge");
  chk_trip_fast: assert property (
    run_r && fcn_s && mode == COF_MODE_ON && force_sel == COF_FRC_NORMAL
    |=> fast_trip_out)
    else $error("start in window did not trip next cycle");
  chk_inhibit_holds: assert property (
    arm_rise && blk_s && !run_r |=> !run_r)
    else $error("inhibited arm opened the window");
  // a switch to a shorter group may leave elapsed past the length for one cycle
  chk_window_bound: assert property (
    run_r && mode_run && elapsed_r >= len_cur |=> !run_r)
    else $error("window ran past its length");
  chk_off_quiet: assert property (
    (mode == COF_MODE_OFF && force_sel == COF_FRC_NORMAL) [*2]
    |-> !run_r ##1 !fast_trip_out && !window_active_out)
    else $error("off mode still drove outputs");
  chk_force_trip: assert property (
    force_sel == COF_FRC_TRIP && mode != COF_MODE_TEST |=> fast_trip_out)
    else $error("forced trip not shown");
  chk_cond_trip: assert property (
    run_r && fcn_s && force_sel == COF_FRC_NORMAL |-> cond == COF_COND_TRIP)
    else $error("condition missed the trip");
  chk_event_off: assert property (
    $fell(run_r) && ev_off_sel && force_sel == COF_FRC_NORMAL
    |=> evt_out.off[COF_EV_ACTIVE])
    else $error("active off event missing");
  chk_counter_step: assert property (
    ev_on[COF_EV_TRIP] && !wr_cnt[COF_EV_TRIP]
    |=> cnt_r[COF_EV_TRIP] == $past(cnt_r[COF_EV_TRIP]) + CNT_W'(1))
    else $error("trip counter did not step");
  chk_expire_quiet: assert property (
    !run_r && !start |=> !run_r)
    else $error("window reopened without rearm");
endmodule
`default_nettype wire

// file: verilog/cof_pkg.sv
`default_nettype none
package cof_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned AW       = 8;
  localparam int unsigned DW       = 32;
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_STAT  = 8'h04;
  localparam logic [7:0]  OFS_IRQ   = 8'h08;
  localparam logic [7:0]  OFS_MASK  = 8'h0C;
  localparam logic [7:0]  OFS_CNT   = 8'h10;
  localparam logic [7:0]  OFS_LEFT  = 8'h20;
  localparam logic [7:0]  OFS_TIME  = 8'h24;
  localparam logic [7:0]  OFS_LSEL  = 8'h28;
  localparam logic [7:0]  OFS_LTS   = 8'h2C;
  localparam logic [7:0]  OFS_LINF  = 8'h30;
  localparam logic [7:0]  OFS_LELP  = 8'h34;
  localparam logic [7:0]  OFS_LEN   = 8'h40;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_FORCE_LSB = 4;
  localparam int unsigned CTRL_EVON_BIT  = 8;
  localparam int unsigned CTRL_EVOFF_BIT = 9;
  localparam int unsigned LINF_GRP_LSB   = 24;
  localparam int unsigned LINF_KIND_LSB  = 28;
  localparam int unsigned LSEL_CNT_LSB   = 8;
  localparam logic [9:0]  CTRL_RST       = 10'h300;
  localparam int unsigned LEN_W          = 21;
  localparam logic [20:0] LEN_RST_MS     = 21'h0_03E8;
  localparam logic [20:0] LEN_MAX_MS     = 21'h1B_7740;
  localparam int unsigned NGRP           = 8;
  localparam int unsigned GRP_W          = 3;
  localparam int unsigned LOG_DEPTH      = 12;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned NEV            = 4;
  // ----------------------------------------
  // timing: one millisecond base tick
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYC      = TICK_NS * 1000 / CLK_PERIOD_PS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    COF_MODE_ON      = 3'b000,
    COF_MODE_BLOCKED = 3'b001,
    COF_MODE_TEST    = 3'b010,
    COF_MODE_TESTBLK = 3'b011,
    COF_MODE_OFF     = 3'b100
  } cof_mode_e;
  typedef enum logic [1:0] {
    COF_FRC_NORMAL  = 2'b00,
    COF_FRC_BLOCKED = 2'b01,
    COF_FRC_ACTIVE  = 2'b10,
    COF_FRC_TRIP    = 2'b11
  } cof_force_e;
  typedef enum logic [2:0] {
    COF_COND_NORMAL  = 3'b000,
    COF_COND_INIT    = 3'b001,
    COF_COND_ACTIVE  = 3'b010,
    COF_COND_TRIP    = 3'b011,
    COF_COND_BLOCKED = 3'b100
  } cof_cond_e;
  // event kinds index the on/off vectors
  typedef enum logic [1:0] {
    COF_EV_INIT   = 2'b00,
    COF_EV_BLOCK  = 2'b01,
    COF_EV_ACTIVE = 2'b10,
    COF_EV_TRIP   = 2'b11
  } cof_ev_e;
  typedef struct packed {
    logic [31:0]      stamp;
    cof_ev_e          kind;
    logic [GRP_W-1:0] grp;
    logic [LEN_W-1:0] left;
    logic [LEN_W-1:0] elapsed;
  } cof_log_s;
  typedef struct packed {
    logic [NEV-1:0] on;
    logic [NEV-1:0] off;
    logic [31:0]    stamp;
  } cof_evt_s;
endpackage
`default_nettype wire

// file: verilog/cof_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cof_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // two stages; only the second stage is read outside
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: verilog/cof_log.sv
`timescale 1ns/1ps
`default_nettype none
module cof_log
  import cof_pkg::*;
#(
  parameter int unsigned DEPTH = LOG_DEPTH
) (
  input  wire logic     mclk,
  input  wire logic     arst_n,
  input  wire logic     wr_en,
  input  wire cof_log_s wr_data,
  input  wire logic [3:0] rd_idx,
  output cof_log_s      rd_data,
  output logic [7:0]    count
);
  if (DEPTH < 2 || DEPTH > 16) begin : g_bad_depth
    $error("cof_log: DEPTH must be 2..16");
  end

  cof_log_s   ent_r [DEPTH];
  logic [3:0] wptr_r;
  logic [4:0] slot;

  // ring of flip-flops, oldest overwritten first
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_r <= '0;
      count  <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        ent_r[i] <= '0;
      end
    end else if (wr_en) begin
      ent_r[wptr_r] <= wr_data;
      wptr_r        <= (wptr_r == 4'(DEPTH - 1)) ? 4'h0 : wptr_r + 4'h1;
      if (count < 8'(DEPTH)) begin
        count <= count + 8'h01;
      end
    end
  end

  // index 0 is the newest entry
  always_comb begin
    slot = 5'(DEPTH) + {1'b0, wptr_r} - 5'h01 - {1'b0, rd_idx};
    if (slot >= 5'(DEPTH)) begin
      slot = slot - 5'(DEPTH);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= (rd_idx < 4'(DEPTH)) ? ent_r[slot[3:0]] : '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  chk_log_keeps_twelve: assert property (
    wr_en && count == 8'(DEPTH) |=> count == 8'(DEPTH))
    else $error("log count left its depth");
  chk_log_grows: assert property (
    wr_en && count < 8'(DEPTH) |=> count == $past(count) + 8'h01)
    else $error("log count did not grow on write");
endmodule
`default_nettype wire

// file: sim/cof_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module cof_field_model
  import cof_pkg::*;
(
  input  wire logic        mclk,
  output logic             arm_trigger_in,
  output logic             inhibit_in,
  output logic             protection_start_in,
  output logic [GRP_W-1:0] setting_group_choice
);
  // ----------------------------------------
  // field levels
  // ----------------------------------------
  // all lines rest low until a scenario moves them
  initial begin
    arm_trigger_in       = 1'b0;
    inhibit_in           = 1'b0;
    protection_start_in  = 1'b0;
    setting_group_choice = '0;
  end
  // close command or digital input, any binary level will do
  task automatic set_arm(input logic v);
    @(posedge mclk);
    arm_trigger_in <= v;
  endtask
  task automatic set_inh(input logic v);
    @(posedge mclk);
    inhibit_in <= v;
  endtask
  // protection stage start, held as a level
  task automatic set_start(input logic v);
    @(posedge mclk);
    protection_start_in <= v;
  endtask
  task automatic set_grp(input logic [GRP_W-1:0] g);
    @(posedge mclk);
    setting_group_choice <= g;
  endtask
endmodule
`default_nettype wire

// file: sim/cof_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module cof_top_test;
  import cof_pkg::*;
  logic             mclk;
  logic             arst_n;
  logic [AW-1:0]    reg_addr;
  logic [DW-1:0]    reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [DW-1:0]    reg_rdata;
  logic             arm;
  logic             inh;
  logic             start;
  logic [GRP_W-1:0] grp;
  logic             active;
  logic             trip;
  logic             irq;
  cof_evt_s         evt;
  logic [DW-1:0]    v;
  int               err_total;
  int               comparisons;
  int               on_seen;
  int               off_seen;
  // ----------------------------------------
  // clock, design and far side
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // short tick keeps each window to 40 or 120 cycles
  cof_top #(.TICK_CYCLES(4)) u_cof_top (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .arm_trigger_in(arm), .inhibit_in(inh), .protection_start_in(start),
    .setting_group_choice(grp), .window_active_out(active), .fast_trip_out(trip),
    .evt_out(evt), .irq(irq));
  cof_field_model u_cof_field_model (.mclk(mclk), .arm_trigger_in(arm), .inhibit_in(inh),
    .protection_start_in(start), .setting_group_choice(grp));
  // single-cycle event pulses are only seen by counting every edge
  always @(posedge mclk) begin
    if (evt.on != '0) on_seen++;
    if (evt.off != '0) off_seen++;
  end
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #60000;
    err_total++;
    give_verdict;
  end
  initial begin
    arst_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    rd(OFS_CTRL); chk("ctrl", v, 32'h0000_0300);
    rd(OFS_STAT); chk("status", v, 32'h0000_0000);
    rd(OFS_LEN); chk("length", v, 32'h0000_03E8);
    rd(8'h80); chk("unmapped", v, 32'h0000_0000);
    wr(OFS_LEN, 32'h0000_000A);
    wr(OFS_LEN + 8'h04, 32'h0000_001E);
    wr(OFS_MASK, 32'h0000_0004);
    // held arm level must not reopen an expired window
    u_cof_field_model.set_arm(1'b1); tick(6);
    chk("active", active, 1); chk("irq", irq, 1);
    tick(60); chk("expired", active, 0);
    tick(20); chk("held arm", active, 0);
    u_cof_field_model.set_start(1'b1); tick(5); chk("late trip", trip, 0);
    u_cof_field_model.set_start(1'b0); u_cof_field_model.set_arm(1'b0);
    wr(OFS_IRQ, 32'h0000_00FF); tick(2); chk("irq clear", irq, 0);
    rd(OFS_LSEL); chk("log count", v[15:8], 1);
    rd(OFS_LINF); chk("log kind", v[29:28], 2);
    // start inside the window trips one cycle after the two-flop sync delay
    u_cof_field_model.set_arm(1'b1); tick(6);
    u_cof_field_model.set_start(1'b1); tick(4); chk("trip", trip, 1);
    rd(OFS_STAT); chk("cond trip", v[2:0], 3);
    u_cof_field_model.set_start(1'b0); u_cof_field_model.set_arm(1'b0); tick(60);
    rd(OFS_CNT + 8'h0C); chk("trip count", v, 1);
    rd(OFS_CNT + 8'h08); chk("active count", v, 2);
    // group 1 holds a longer window than group 0
    u_cof_field_model.set_grp(3'd1); tick(3);
    u_cof_field_model.set_arm(1'b1); tick(58); chk("group len", active, 1);
    tick(80); chk("group end", active, 0);
    u_cof_field_model.set_arm(1'b0); u_cof_field_model.set_grp(3'd0);
    u_cof_field_model.set_inh(1'b1); tick(3);
    u_cof_field_model.set_arm(1'b1); tick(8); chk("inhibited", active, 0);
    rd(OFS_STAT); chk("cond blocked", v[2:0], 4);
    u_cof_field_model.set_arm(1'b0); u_cof_field_model.set_inh(1'b0);
    // test mode runs the window but holds the trip output low
    wr(OFS_CTRL, 32'h0000_0302); tick(3);
    u_cof_field_model.set_arm(1'b1); tick(6);
    u_cof_field_model.set_start(1'b1); tick(4); chk("test trip", trip, 0);
    rd(OFS_STAT); chk("test cond", v[2:0], 3);
    u_cof_field_model.set_start(1'b0); u_cof_field_model.set_arm(1'b0); tick(60);
    for (int m = 0; m < 5; m++) begin
      wr(OFS_CTRL, 32'h0000_0300 | m);
      rd(OFS_STAT); chk("behaviour", v[6:4], m);
    end
    wr(OFS_CTRL, 32'h0000_0320); tick(3); chk("force act", active, 1);
    wr(OFS_CTRL, 32'h0000_0330); tick(3); chk("force trip", trip, 1);
    wr(OFS_CTRL, 32'h0000_0300); tick(3);
    // on events only: no off pulse may pass
    wr(OFS_CTRL, 32'h0000_0100); tick(2);
    on_seen = 0; off_seen = 0;
    u_cof_field_model.set_arm(1'b1); tick(60);
    u_cof_field_model.set_arm(1'b0); tick(5);
    chk("on events", on_seen > 0, 1);
    chk("off events", off_seen, 0);
    wr(OFS_CNT, 32'h0000_0000); rd(OFS_CNT); chk("cnt clear", v, 0);
    give_verdict;
  end
endmodule
`default_nettype wire
